// >>> host_link_model.sv
`timescale 1ns/1ps
// Host end of the serial link: each frame shows as a one-cycle pulse
module host_link_model (
   input  wire logic pclk,
   output logic      frame_ok,
   output logic      frame_err
);
   // Line idle, no frame
   initial begin
      frame_ok  = 1'b0;
      frame_err = 1'b0;
   end
   // One frame, damaged only when asked, then idle gap so pulses never merge
   task automatic send(input logic bad);
      frame_ok  <= !bad;
      frame_err <= bad;
      @(posedge pclk);
      frame_ok  <= 1'b0;
      frame_err <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
endmodule // host_link_model

// >>> link_supervisor_defines.vh
`ifndef LINK_SUPERVISOR_DEFINES_VH
`define LINK_SUPERVISOR_DEFINES_VH
// Register byte offsets on the APB
`define OFF_RETRY      12'h000
`define OFF_SILENCE    12'h004
`define OFF_CTRL       12'h008
`define OFF_OUTFN      12'h00c
`define OFF_STATUS     12'h010
// Reset values, disable code and range limits
`define RETRY_RST      14'h0001
`define SILENCE_RST    14'h0000
`define DISABLE_VAL    14'h270f
`define RETRY_MAX      14'h000a
`define SILENCE_MAX    14'h270e
// Output terminal function codes
`define FN_ALARM_POS   8'h62
`define FN_ALARM_NEG   8'hc6
`define FN_WIDTH       8
// Control register fields
`define CTRL_MODE_LSB  0
`define CTRL_PROTO_BIT 2
`define CTRL_NETRUN    3
`define CTRL_CLEAR     4
`define CTRL_RST       5'h00
// Status register fields
`define ST_FAULT       0
`define ST_FAULTOUT    1
`define ST_ALARM       2
`define ST_STOPPED     3
`define ST_RESTART     4
// Silence tick: 0.1 s at 40 MHz
`define TICK_NS        100000000
`define CLK_NS         25
`define TICK_CYC       (`TICK_NS / `CLK_NS)
`endif

// >>> serial_link_fault_supervisor.v
`timescale 1ns/1ps
// Notes on behaviour
// - Retry limit 0..10, default one
// - Errors beyond limit trip link fault
// - Disable value: no trip, minor alarm
// - Alarm only on terminals coded 98/198
// - Retry counting only under ASCII protocol
// - Silence beyond interval trips link fault
// - Disable value turns silence check off
// - Zero interval trips on entering link mode
// - Mode 2 restart reuses prior run and speed
// - Mode 2: removal during decel re-accelerates immediately
// - Any frame clears silence counter
// - Silence check starts at first frame
`include "link_supervisor_defines.vh"

// Watchdog for the host serial link. Receive errors are counted against the
// retry limit and line silence is timed in 0.1 s steps; either one trips the
// stop sequencer, which coasts or decelerates the motor per the stop mode.
module serial_link_fault_supervisor #(
   parameter TICK_CYCLES = `TICK_CYC     // Cycles per 0.1 s step
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        frame_ok,          // Pulse: good frame received, any station
   input  wire        frame_err,         // Pulse: frame received with error
   input  wire        motor_stopped,     // Level: speed has reached zero
   input  wire        run_cmd,           // Run command from link
   input  wire [15:0] speed_cmd,         // Speed command from link
   output reg         coast_r,           // Output drive off, motor coasts
   output reg         decel_r,           // Decelerate to stop
   output reg         run_out_r,         // Run command to drive
   output reg  [15:0] speed_out_r,       // Speed command to drive
   output reg         fault_show_r,      // Display shows link fault code
   output reg         fault_out_r,       // Fault output terminal
   output reg  [2:0]  term_out_r         // Terminals a, b, c
);

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   // Limits and codes are held as software wrote them; writes outside a
   // field's legal range are dropped rather than clamped.
   reg [13:0] retry_limit_setting;      // Retry limit
   reg [13:0] silence_check_interval;   // Interval in 0.1 s units
   reg [1:0]  fault_stop_mode;          // Stop mode select
   reg        proto_modbus;             // 1 = binary protocol active
   reg        networked_run_mode;       // Link is control source
   reg [`FN_WIDTH-1:0] output_terminal_function_a;
   reg [`FN_WIDTH-1:0] output_terminal_function_b;
   reg [`FN_WIDTH-1:0] output_terminal_function_c;
   reg        clear_pulse;              // Software fault clear
   wire       wr_en = psel & penable & pwrite;
   wire       mapped = (paddr == `OFF_RETRY) | (paddr == `OFF_SILENCE) | (paddr == `OFF_CTRL) |
                       (paddr == `OFF_OUTFN) | (paddr == `OFF_STATUS);

   // Every register answers in the first access cycle, so the slave never
   // stretches a transfer; an access to a hole answers with pslverr and reads 0.
   assign pready  = 1'b1;                // Zero wait states
   assign pslverr = psel & penable & ~mapped;

   // Register writes; out-of-range limits are refused and keep old value
   // The clear bit is a one-cycle pulse, so it cannot hold a fault cleared.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retry_limit_setting        <= `RETRY_RST;
         silence_check_interval     <= `SILENCE_RST;
         fault_stop_mode            <= 2'h0;
         proto_modbus               <= 1'b0;
         networked_run_mode         <= 1'b0;
         output_terminal_function_a <= 8'h00;
         output_terminal_function_b <= 8'h00;
         output_terminal_function_c <= 8'h00;
         clear_pulse                <= 1'b0;
      end else begin
         clear_pulse <= 1'b0;
         if (wr_en) begin
            case (paddr)
               `OFF_RETRY: begin
                  if (pwdata[13:0] <= `RETRY_MAX || pwdata[13:0] == `DISABLE_VAL)
                     retry_limit_setting <= pwdata[13:0];
               end
               `OFF_SILENCE: begin
                  if (pwdata[13:0] <= `SILENCE_MAX || pwdata[13:0] == `DISABLE_VAL)
                     silence_check_interval <= pwdata[13:0];
               end
               `OFF_CTRL: begin
                  if (pwdata[1:0] != 2'h3)
                     fault_stop_mode <= pwdata[1:0];
                  proto_modbus       <= pwdata[`CTRL_PROTO_BIT];
                  networked_run_mode <= pwdata[`CTRL_NETRUN];
                  clear_pulse        <= pwdata[`CTRL_CLEAR];
               end
               `OFF_OUTFN: begin
                  output_terminal_function_a <= pwdata[7:0];
                  output_terminal_function_b <= pwdata[15:8];
                  output_terminal_function_c <= pwdata[23:16];
               end
               default: begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error counting and silence timing
   reg [3:0]  err_cnt_r;                // Consecutive receive errors
   reg        minor_link_alarm;         // Alarm level, follows last frame
   reg        silence_armed_r;          // Armed after first frame in link mode
   reg [13:0] silence_cnt_r;            // 0.1 s steps of silence
   reg [31:0] tick_cnt_r;               // Prescaler
   reg        net_d_r;                  // Link mode, delayed
   wire       tick = (tick_cnt_r == TICK_CYCLES - 1);
   wire       retry_dis = (retry_limit_setting == `DISABLE_VAL);
   wire       silence_dis = (silence_check_interval == `DISABLE_VAL);
   wire       retry_trip = frame_err & ~proto_modbus & ~retry_dis &
                           ({10'h000, err_cnt_r} >= retry_limit_setting);
   wire       silence_trip = networked_run_mode & ~silence_dis & (
                  (silence_check_interval == 14'h0000 & ~net_d_r) |
                  (silence_armed_r & silence_check_interval != 14'h0000 &
                   tick & silence_cnt_r >= silence_check_interval));
   // Either source trips the same sequencer; the zero interval fires once, on
   // the first cycle of link mode, while communication itself keeps working.
   wire       trip = retry_trip | silence_trip;

   // Counters; the 0.1 s tick means a trip lands within one step of the limit.
   // The prescaler runs free rather than restarting on each frame: this keeps the
   // logic small, at the price of up to one step of jitter on the silence time.
   // The error counter saturates so a long burst cannot wrap back below the limit.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cnt_r        <= 4'h0;
         minor_link_alarm <= 1'b0;
         silence_armed_r  <= 1'b0;
         silence_cnt_r    <= 14'h0000;
         tick_cnt_r       <= 32'h0000_0000;
         net_d_r          <= 1'b0;
      end else begin
         net_d_r    <= networked_run_mode;
         tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
         // Consecutive count resets on a good frame; an error in the same cycle wins
         if (frame_err && !proto_modbus) begin
            if (err_cnt_r != 4'hf)
               err_cnt_r <= err_cnt_r + 4'h1;
            minor_link_alarm <= retry_dis;
         end else if (frame_ok) begin
            err_cnt_r        <= 4'h0;
            minor_link_alarm <= 1'b0;
         end
         // Silence supervision only inside link mode
         // Leaving link mode disarms it, so the next entry waits for a fresh frame
         if (!networked_run_mode) begin
            silence_armed_r <= 1'b0;
            silence_cnt_r   <= 14'h0000;
         end else if (frame_ok || frame_err) begin
            silence_armed_r <= 1'b1;
            silence_cnt_r   <= 14'h0000;
         end else if (tick && silence_armed_r && silence_cnt_r != 14'h3fff) begin
            silence_cnt_r <= silence_cnt_r + 14'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stop sequencer, one-hot
   // Modes 0 and 1 latch the fault until software writes the clear bit; mode 2
   // watches the fault condition itself and restarts on its own once it is gone.
   // The condition is held in cond_r because a silence trip is only a pulse at a
   // tick, while removal needs a good frame or leaving link mode.
   localparam [4:0] S_RUN     = 5'b00001;
   localparam [4:0] S_COAST   = 5'b00010;  // Mode 0, latched
   localparam [4:0] S_DECEL   = 5'b00100;  // Mode 1 or 2 decelerating
   localparam [4:0] S_HOLD    = 5'b01000;  // Mode 1 stopped, latched
   localparam [4:0] S_WAIT    = 5'b10000;  // Mode 2 stopped, awaiting removal
   reg [4:0]  state_r;
   reg [4:0]  state_nxt;
   reg        cond_r;                      // Fault condition still present
   reg        run_hold_r;                  // Commands saved at fault
   reg [15:0] speed_hold_r;
   wire       cond_gone = ~trip & (frame_ok | ~networked_run_mode);

   // Next state
   // Deceleration in mode 2 is cut short as soon as the condition clears;
   // otherwise the sequencer waits for the drive to report zero speed.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_RUN: begin
            if (trip)
               state_nxt = (fault_stop_mode == 2'h0) ? S_COAST : S_DECEL;
         end
         S_COAST: begin
            // A trip in the clearing cycle keeps the fault latched
            state_nxt = (clear_pulse && !trip) ? S_RUN : S_COAST;
         end
         S_DECEL: begin
            if (fault_stop_mode == 2'h2 && !cond_r)
               state_nxt = S_RUN;
            else if (motor_stopped)
               state_nxt = (fault_stop_mode == 2'h2) ? S_WAIT : S_HOLD;
         end
         S_HOLD: begin
            // Same priority as coasting: a new trip beats the clear
            state_nxt = (clear_pulse && !trip) ? S_RUN : S_HOLD;
         end
         S_WAIT: begin
            state_nxt = cond_r ? S_WAIT : S_RUN;
         end
         default: state_nxt = S_RUN;
      endcase
   end

   // State, saved commands and drive outputs
   // Outputs are decoded from the next state so they change in the same cycle
   // as the state register; commands are captured only on the trip out of run,
   // so a retrip while stopped cannot overwrite what the restart will reuse.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r      <= S_RUN;
         cond_r       <= 1'b0;
         run_hold_r   <= 1'b0;
         speed_hold_r <= 16'h0000;
         coast_r      <= 1'b0;
         decel_r      <= 1'b0;
         run_out_r    <= 1'b0;
         speed_out_r  <= 16'h0000;
         fault_show_r <= 1'b0;
         fault_out_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // New trip wins over removal in the same cycle
         if (trip)
            cond_r <= 1'b1;
         else if (cond_gone)
            cond_r <= 1'b0;
         if (state_r == S_RUN && trip) begin
            run_hold_r   <= run_cmd;
            speed_hold_r <= speed_cmd;
         end
         coast_r      <= (state_nxt == S_COAST);
         decel_r      <= (state_nxt == S_DECEL);
         fault_show_r <= (state_nxt == S_COAST) | (state_nxt == S_HOLD) | (state_nxt == S_WAIT);
         fault_out_r  <= (state_nxt == S_COAST) | (state_nxt == S_HOLD);
         if (state_nxt == S_RUN && state_r != S_RUN && fault_stop_mode == 2'h2) begin
            run_out_r   <= run_hold_r;
            speed_out_r <= speed_hold_r;
         end else if (state_nxt == S_RUN) begin
            run_out_r   <= run_cmd;
            speed_out_r <= speed_cmd;
         end else begin
            run_out_r   <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output terminals: alarm shown only where selected, either sense
   // A terminal with any other code is held low here; its own function is
   // produced elsewhere in the drive and merged outside this block.
   wire [`FN_WIDTH*3-1:0] fn_all = {output_terminal_function_c, output_terminal_function_b,
                                    output_terminal_function_a};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_term
         always @(posedge pclk or negedge presetn) begin
            if (!presetn)
               term_out_r[gi] <= 1'b0;
            else if (fn_all[gi*8 +: 8] == `FN_ALARM_POS)
               term_out_r[gi] <= minor_link_alarm;
            else if (fn_all[gi*8 +: 8] == `FN_ALARM_NEG)
               term_out_r[gi] <= ~minor_link_alarm;
            else
               term_out_r[gi] <= 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   // Combinational, valid while the address is held; the clear bit is not
   // stored and always reads back as zero.
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `OFF_RETRY:   prdata = {18'h00000, retry_limit_setting};
         `OFF_SILENCE: prdata = {18'h00000, silence_check_interval};
         `OFF_CTRL:    prdata = {28'h0000000, networked_run_mode, proto_modbus, fault_stop_mode};
         `OFF_OUTFN:   prdata = {8'h00, fn_all};
         `OFF_STATUS:  prdata = {16'h0000, err_cnt_r, 7'h00, state_r == S_WAIT,
                                 state_r != S_RUN, minor_link_alarm, fault_out_r, fault_show_r};
         default:      prdata = 32'h0000_0000;
      endcase
   end

endmodule // serial_link_fault_supervisor

// >>> serial_link_fault_supervisor_asserts.sv
`timescale 1ns/1ps
// Watches the APB answer and the stop outputs of the supervisor
module sl_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        motor_stopped,
   input wire logic        coast_r,
   input wire logic        decel_r,
   input wire logic        fault_show_r,
   input wire logic        fault_out_r
);
   // One clock domain, so one clocking and one reset for all
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Software clear of a latched fault, as the slave takes it
   wire clr_wr = psel && penable && pwrite && paddr == 12'h008 && pwdata[4];
   ////////////////////////////////////////////////////////////////////////////////
   // Bus answer: zero wait states, error only on an unmapped access
   pready_high_a: assert property (pready) else $error("pready low");
   unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no pslverr");
   idle_noerr_a: assert property (!(psel && penable) |-> !pslverr) else $error("pslverr outside access");
   ////////////////////////////////////////////////////////////////////////////////
   // Stop handling; coasting shows and signals the fault at once
   coast_shows_a: assert property ($rose(coast_r) |-> fault_show_r && fault_out_r)
      else $error("coast without fault");
   stop_excl_a: assert property (!(coast_r && decel_r))
      else $error("coast and decel together");
   out_needs_show_a: assert property (fault_out_r |-> fault_show_r)
      else $error("fault output without display");
   decel_no_out_a: assert property ($rose(decel_r) |-> !fault_out_r)
      else $error("fault output at decel start");
   // Decelerating modes only raise the output once the motor is still
   out_after_stop_a: assert property ($rose(fault_out_r) |-> coast_r || $past(motor_stopped))
      else $error("fault output before stop");
   // Latched until software writes the clear bit
   // The clear takes two edges to reach the output: bit taken, then state left
   fault_latch_a: assert property (fault_out_r && !clr_wr && !$past(clr_wr) |=> fault_out_r)
      else $error("fault output dropped");
endmodule // sl_checker

bind serial_link_fault_supervisor sl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .motor_stopped(motor_stopped), .coast_r(coast_r), .decel_r(decel_r),
   .fault_show_r(fault_show_r), .fault_out_r(fault_out_r));

// >>> test_serial_link_fault_supervisor.sv
`timescale 1ns/1ps
`include "link_supervisor_defines.vh"
// Drives the supervisor over APB and the host model, plays a simple motor
module test_serial_link_fault_supervisor;
   `define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
      $display("Error %s expected %0h seen %0h", n, e, s); end end
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        frame_ok, frame_err, motor_stopped, run_cmd;
   logic        coast_r, decel_r, run_out_r, fault_show_r, fault_out_r, run_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] speed_cmd, speed_out_r, sp, restart_sp;
   logic [2:0]  term_out_r, stop_cnt;
   int          seed, n_fail, comparisons, k, lim;
   host_link_model host (.pclk(pclk), .frame_ok(frame_ok), .frame_err(frame_err));
   serial_link_fault_supervisor #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_ok(frame_ok), .frame_err(frame_err), .motor_stopped(motor_stopped),
      .run_cmd(run_cmd), .speed_cmd(speed_cmd), .coast_r(coast_r), .decel_r(decel_r), .run_out_r(run_out_r),
      .speed_out_r(speed_out_r), .fault_show_r(fault_show_r), .fault_out_r(fault_out_r), .term_out_r(term_out_r));
   ////////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Motor spins down six cycles after a stop; far quicker than a real drive
   always @(posedge pclk) begin
      stop_cnt      <= (coast_r | decel_r) ? stop_cnt - {2'b0, |stop_cnt} : 3'h5;
      motor_stopped <= (coast_r | decel_r) && stop_cnt == 3'h0;
      // Speed seen as the drive output comes back on, for the restart check
      run_q         <= run_out_r;
      if (run_out_r && !run_q)
         restart_sp <= speed_out_r;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, reached from the end of the run or from any expired wait
   task final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One APB transfer; read data and error taken at the pready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rdata = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // One idle edge, so the next call never re-drives psel in this time step
            @(posedge pclk);
            return;
         end
      end
      n_fail++;
      final_report();
   endtask
   // Bounded wait: 0 fault shown, 1 fault output, 2 running, 3 decelerating
   task wt(input int s);
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge pclk);
         if ((s == 0 && fault_show_r === 1'b1) || (s == 1 && fault_out_r === 1'b1) ||
             (s == 2 && run_out_r === 1'b1) || (s == 3 && decel_r === 1'b1)) return;
      end
      n_fail++;
      final_report();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 3; n_fail = 0; comparisons = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; run_cmd = 1'b0; speed_cmd = 16'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `OFF_RETRY, 0); `CHK("retry reset", 32'h1, rdata)
      apb(1, `OFF_RETRY, 11); apb(0, `OFF_RETRY, 0); `CHK("retry range", 32'h1, rdata)
      apb(1, `OFF_SILENCE, 10000); apb(1, `OFF_CTRL, 32'h03); apb(0, `OFF_SILENCE, 0);
      `CHK("interval range", 32'h0, rdata)
      apb(0, `OFF_CTRL, 0); `CHK("mode range", 32'h0, rdata)
      apb(0, 12'h020, 0); `CHK("unmapped err", 1'b1, err)
      apb(1, `OFF_CTRL, 32'h08); wt(0); `CHK("zero interval", 1'b1, coast_r)
      $display("registers and zero interval done");
      // Retry limit corners 0 and 10 then a random one; a good frame breaks the run
      apb(1, `OFF_SILENCE, 9999); apb(1, `OFF_CTRL, 32'h18);
      for (k = 0; k < 3; k++) begin
         lim = (k == 0) ? 0 : (k == 1) ? 10 : {$random(seed)} % 11;
         apb(1, `OFF_RETRY, lim); host.send(0);
         repeat (lim) host.send(1);
         host.send(0);
         repeat (lim) host.send(1);
         `CHK("no trip", 1'b0, fault_show_r)
         host.send(1); `CHK("trip", 1'b1, fault_out_r)
         apb(1, `OFF_CTRL, 32'h18);
      end
      // Binary protocol ignores receive errors
      apb(1, `OFF_RETRY, 0); apb(1, `OFF_CTRL, 32'h1c);
      repeat (3) host.send(1);
      `CHK("binary", 1'b0, fault_show_r)
      // Retry disabled: alarm on terminals a (high) and b (low) only
      apb(1, `OFF_CTRL, 32'h18); apb(1, `OFF_RETRY, 9999); apb(1, `OFF_OUTFN, 32'h0000c662);
      host.send(0); `CHK("alarm off", 3'b010, term_out_r)
      repeat (3) host.send(1);
      `CHK("alarm on", 3'b001, term_out_r)
      `CHK("no trip disabled", 1'b0, fault_show_r)
      host.send(0); `CHK("alarm clear", 3'b010, term_out_r)
      $display("retry tests done");
      // Silence in mode 1: armed only by a frame, kept alive by frames
      apb(1, `OFF_SILENCE, 3); apb(1, `OFF_CTRL, 32'h11); apb(1, `OFF_CTRL, 32'h09);
      repeat (100) @(posedge pclk);
      `CHK("unarmed", 1'b0, fault_show_r)
      repeat (4) begin host.send(0); repeat (12) @(posedge pclk); end
      `CHK("kept alive", 1'b0, fault_show_r)
      wt(3); `CHK("decel out", 1'b0, fault_out_r)
      wt(1); `CHK("shown", 1'b1, fault_show_r)
      // Mode 2: restart with the commands held at the trip
      sp = $random(seed); run_cmd <= 1'b1; speed_cmd <= sp;
      apb(1, `OFF_CTRL, 32'h12); apb(1, `OFF_CTRL, 32'h0a); host.send(0);
      wt(3); speed_cmd <= ~sp;
      wt(0); `CHK("mode2 no out", 1'b0, fault_out_r)
      // Two frames: one landing on a silence retrip leaves the condition set
      host.send(0); host.send(0); wt(2); @(posedge pclk);
      `CHK("restart speed", sp, restart_sp)
      `CHK("restart clear", 1'b0, fault_show_r)
      $display("silence tests done");
      final_report();
   end
endmodule // test_serial_link_fault_supervisor
